/* File: cicms_regs.vh */
// Shared constants of the CIC multirate stream filter
`ifndef CICMS_REGS_VH
`define CICMS_REGS_VH

// ------------------------------------------------------------
// Filter type and multichannel timing mode
// ------------------------------------------------------------
`define CICMS_TYPE_DECIM 1'b0
`define CICMS_TYPE_INTERP 1'b1
`define CICMS_MODE_BLOCK 1'b0
`define CICMS_MODE_STREAM 1'b1

// ------------------------------------------------------------
// Default sizes, rates and timing counts
// ------------------------------------------------------------
`define CICMS_NUM_CH 1
`define CICMS_CH_W 1
`define CICMS_DATA_W 16
`define CICMS_RATE_W 14
`define CICMS_INIT_RATE 14'h0004
`define CICMS_IN_PERIOD 14'h0001
`define CICMS_BUF_DEPTH 16
`define CICMS_BUF_AW 4

`endif

/* File: cicms_fifo.v */
// Output sample buffer with registered read port
`timescale 1ns/100ps
`default_nettype none

module cicms_fifo #(
  parameter W = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // Fill side
  input wire wr_valid,
  input wire [W-1:0] wr_data,
  output wire wr_ready,
  output wire [AW:0] level,
  // Drain side
  output wire rd_valid,
  output wire [W-1:0] rd_data,
  input wire rd_ready
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] count_reg;
  reg rd_valid_reg;
  reg [W-1:0] rd_data_reg;

  wire do_wr = wr_valid && wr_ready;
  wire load = (count_reg != {(AW+1){1'b0}}) && (!rd_valid_reg || rd_ready);

  assign wr_ready = (count_reg < DEPTH[AW:0]);
  assign level = count_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;

  // Storage carries no reset so it can map onto distributed RAM
  always @(posedge clk_sys) begin
    if (ce && do_wr) begin
      mem[wptr_reg] <= wr_data;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      rd_valid_reg <= 1'b0;
      rd_data_reg <= {W{1'b0}};
    end else if (ce) begin
      if (do_wr) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (load) begin
        rd_data_reg <= mem[rptr_reg];
        rptr_reg <= rptr_reg + 1'b1;
        rd_valid_reg <= 1'b1;
      end else if (rd_ready) begin
        rd_valid_reg <= 1'b0;
      end
      count_reg <= count_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, load};
    end
  end

endmodule
`default_nettype wire

/* File: cicms_filter.v */
// CIC multirate stream filter: rate, channel and handshake timing
`timescale 1ns/100ps
`default_nettype none
`include "cicms_regs.vh"
// ------------------------------------------------------------
// ------------------------------------------------------------

module cicms_filter #(
  parameter FILTER_TYPE = `CICMS_TYPE_DECIM,
  parameter TIMING_MODE = `CICMS_MODE_BLOCK,
  parameter HAS_DOUT_READY = 0,
  parameter NUM_CH = `CICMS_NUM_CH,
  parameter CH_W = `CICMS_CH_W,
  parameter DATA_W = `CICMS_DATA_W,
  parameter RATE_W = `CICMS_RATE_W,
  parameter [RATE_W-1:0] INIT_RATE = `CICMS_INIT_RATE,
  parameter [RATE_W-1:0] IN_PERIOD = `CICMS_IN_PERIOD,
  parameter BUF_DEPTH = `CICMS_BUF_DEPTH,
  parameter BUF_AW = `CICMS_BUF_AW
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // Sample input channel
  input wire din_valid,
  input wire [DATA_W-1:0] din_data,
  output wire din_ready,
  // Rate configuration channel
  input wire cfg_valid,
  input wire [RATE_W-1:0] cfg_rate,
  output wire cfg_ready,
  // Sample output channel
  output wire dout_valid,
  output wire [DATA_W+RATE_W-1:0] dout_data,
  output wire first_channel_marker,
  output wire [CH_W-1:0] output_channel_number,
  input wire dout_ready
);

  localparam ACC_W = DATA_W + RATE_W;
  localparam FW = ACC_W + 1 + CH_W;
  localparam [CH_W-1:0] LAST_CH = NUM_CH[CH_W-1:0] - 1'b1;
  localparam [CH_W:0] FULL_CNT = NUM_CH[CH_W:0];
  localparam [BUF_AW:0] ROOM = BUF_DEPTH[BUF_AW:0] - NUM_CH[BUF_AW:0] - 2'd2;
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam IS_INT = (FILTER_TYPE == `CICMS_TYPE_INTERP);
  localparam IS_STR = (TIMING_MODE == `CICMS_MODE_STREAM);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg din_ready_reg;
  reg cfg_ready_reg;
  reg [CH_W-1:0] in_ch_reg;
  reg [RATE_W-1:0] phase_reg;
  reg [RATE_W-1:0] gap_reg;
  reg [RATE_W-1:0] rate_reg;
  reg [RATE_W-1:0] new_rate_reg;
  reg rate_pend_reg;
  reg run_reg;
  reg [CH_W-1:0] och_reg;
  reg [RATE_W-1:0] rep_reg;
  reg [RATE_W-1:0] frame_rate_reg;
  reg [CH_W:0] pend_cnt_reg;
  wire [NUM_CH*ACC_W-1:0] acc_flat;
  wire [NUM_CH*ACC_W-1:0] res_flat;
  wire [NUM_CH*DATA_W-1:0] held_flat;
  wire [BUF_AW:0] buf_level;
  wire buf_rd_valid;
  wire [FW-1:0] buf_rd_data;

  // ------------------------------------------------------------
  // Handshakes and frame bookkeeping
  // ------------------------------------------------------------
  wire accept = din_valid && din_ready_reg;
  wire cfg_take = cfg_valid && cfg_ready_reg;
  wire first_in = (in_ch_reg == {CH_W{1'b0}});
  wire last_in = (in_ch_reg == LAST_CH);
  wire [RATE_W-1:0] rate_use = (rate_pend_reg && first_in) ?
    new_rate_reg : rate_reg;
  // Channel frame ends on its R-th sample
  wire fend = (phase_reg >= rate_use - 1'b1);
  wire fifo_room = (buf_level < ROOM);
  wire [ACC_W-1:0] din_ext = {{RATE_W{din_data[DATA_W-1]}}, din_data};
  wire step = run_reg && fifo_room;
  wire run_end = step && (och_reg == LAST_CH) &&
    (!IS_INT || rep_reg >= frame_rate_reg - 1'b1);
  wire take = IS_INT && (!run_reg || run_end) &&
    (pend_cnt_reg == FULL_CNT);
  wire [ACC_W-1:0] acc_sel = acc_flat[in_ch_reg*ACC_W +: ACC_W];
  wire [ACC_W-1:0] res_sel = res_flat[och_reg*ACC_W +: ACC_W];
  wire [DATA_W-1:0] held_sel = held_flat[och_reg*DATA_W +: DATA_W];
  wire str_wr = !IS_INT && IS_STR && accept && fend;
  reg [RATE_W-1:0] gap_next;
  reg [CH_W:0] pend_cnt_next;
  reg rate_pend_next;
  reg din_ready_next;
  reg buf_wr_valid;
  reg [FW-1:0] buf_wr_data;

  always @* begin
    // Pacing: decimator by input period, streaming interpolator without dout_ready by R
    if (accept) begin
      if (!IS_INT) begin
        gap_next = IN_PERIOD - 1'b1;
      end else if (IS_STR && !HAS_DOUT_READY) begin
        gap_next = rate_reg - 1'b1;
      end else begin
        gap_next = {RATE_W{1'b0}};
      end
    end else begin
      gap_next = (gap_reg == {RATE_W{1'b0}}) ? gap_reg : gap_reg - 1'b1;
    end
    pend_cnt_next = take ? {(CH_W+1){1'b0}} :
      pend_cnt_reg + {{CH_W{1'b0}}, accept};
    rate_pend_next = cfg_take ||
      (rate_pend_reg && !(accept && first_in));
    if (IS_INT) begin
      // Ready holds while the pending frame has space and the pacing gap is zero
      din_ready_next = (gap_next == {RATE_W{1'b0}}) &&
        (pend_cnt_next < FULL_CNT);
    end else begin
      din_ready_next = (gap_next == {RATE_W{1'b0}}) && fifo_room;
    end
    buf_wr_valid = str_wr || step;
    if (str_wr) begin
      buf_wr_data = {first_in, in_ch_reg, acc_sel + din_ext};
    end else if (IS_INT) begin
      buf_wr_data = {och_reg == {CH_W{1'b0}}, och_reg,
        {{RATE_W{held_sel[DATA_W-1]}}, held_sel}};
    end else begin
      buf_wr_data = {och_reg == {CH_W{1'b0}}, och_reg, res_sel};
    end
  end

  // ------------------------------------------------------------
  // Per-channel storage
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      localparam [31:0] GI = g;
      localparam [CH_W-1:0] ME = GI[CH_W-1:0];
      reg [ACC_W-1:0] acc_reg;
      reg [ACC_W-1:0] res_reg;
      reg [DATA_W-1:0] pend_reg;
      reg [DATA_W-1:0] held_reg;
      assign res_flat[g*ACC_W +: ACC_W] = res_reg;
      assign held_flat[g*DATA_W +: DATA_W] = held_reg;
      assign acc_flat[g*ACC_W +: ACC_W] = acc_reg;
      always @(posedge clk_sys) begin
        if (srst) begin
          acc_reg <= {ACC_W{1'b0}};
          res_reg <= {ACC_W{1'b0}};
          pend_reg <= {DATA_W{1'b0}};
          held_reg <= {DATA_W{1'b0}};
        end else if (ce) begin
          if (accept && in_ch_reg == ME) begin
            // Order-one integrate and dump per channel
            acc_reg <= fend ? {ACC_W{1'b0}} : acc_reg + din_ext;
            if (fend) begin
              res_reg <= acc_reg + din_ext;
            end
            pend_reg <= din_data;
          end
          if (take) begin
            held_reg <= pend_reg;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Control
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      din_ready_reg <= 1'b0;
      cfg_ready_reg <= 1'b0;
      in_ch_reg <= {CH_W{1'b0}};
      phase_reg <= {RATE_W{1'b0}};
      gap_reg <= {RATE_W{1'b0}};
      rate_reg <= INIT_RATE;
      new_rate_reg <= INIT_RATE;
      rate_pend_reg <= 1'b0;
      run_reg <= ST_IDLE;
      och_reg <= {CH_W{1'b0}};
      rep_reg <= {RATE_W{1'b0}};
      frame_rate_reg <= INIT_RATE;
      pend_cnt_reg <= {(CH_W+1){1'b0}};
    end else if (ce) begin
      din_ready_reg <= din_ready_next;
      gap_reg <= gap_next;
      pend_cnt_reg <= pend_cnt_next;
      rate_pend_reg <= rate_pend_next;
      cfg_ready_reg <= !rate_pend_next;
      if (cfg_take) begin
        new_rate_reg <= cfg_rate;
      end else if (rate_pend_reg && accept && first_in) begin
        rate_reg <= new_rate_reg;
      end
      if (accept) begin
        in_ch_reg <= last_in ? {CH_W{1'b0}} : in_ch_reg + 1'b1;
        if (last_in) begin
          phase_reg <= fend ? {RATE_W{1'b0}} : phase_reg + 1'b1;
        end
      end
      case (run_reg)
        ST_IDLE: begin
          if (take) begin
            run_reg <= ST_RUN;
            frame_rate_reg <= rate_reg;
          end else if (!IS_INT && !IS_STR && accept && last_in && fend) begin
            run_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (run_end) begin
            och_reg <= {CH_W{1'b0}};
            rep_reg <= {RATE_W{1'b0}};
            if (take) begin
              frame_rate_reg <= rate_reg;
            end else begin
              run_reg <= ST_IDLE;
            end
          end else if (step) begin
            if (och_reg == LAST_CH) begin
              och_reg <= {CH_W{1'b0}};
              rep_reg <= rep_reg + 1'b1;
            end else begin
              och_reg <= och_reg + 1'b1;
            end
          end
        end
        default: begin
          run_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Output buffer
  // ------------------------------------------------------------
  // Without downstream ready the drain never stalls, so the buffer
  // only adds fixed latency; a slow slave then loses samples.
  cicms_fifo #(
    .W(FW),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .wr_valid(buf_wr_valid),
    .wr_data(buf_wr_data),
    .wr_ready(),
    .level(buf_level),
    .rd_valid(buf_rd_valid),
    .rd_data(buf_rd_data),
    .rd_ready(HAS_DOUT_READY ? dout_ready : 1'b1)
  );

  assign din_ready = din_ready_reg;
  assign cfg_ready = cfg_ready_reg;
  assign dout_valid = buf_rd_valid;
  assign dout_data = buf_rd_data[ACC_W-1:0];
  assign output_channel_number = buf_rd_data[ACC_W +: CH_W];
  assign first_channel_marker = buf_rd_data[FW-1];

endmodule
`default_nettype wire

/* File: cicms_checker.sv */
// Port checker for the decimating CIC stream filter
`timescale 1ns/100ps
`default_nettype none
module cicms_checker #(
  parameter CH_W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Handshakes
  input wire logic din_valid,
  input wire logic din_ready,
  input wire logic cfg_valid,
  input wire logic cfg_ready,
  // Output stream
  input wire logic dout_valid,
  input wire logic first_channel_marker,
  input wire logic [CH_W-1:0] output_channel_number
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire take = din_valid && din_ready;
  // ----------------------------------------
  // Properties, single channel, rate 4 or more
  // ----------------------------------------
  property p_rst_quiet;
    $fell(srst) |-> !dout_valid && !din_ready && !cfg_ready;
  endproperty
  property p_rdy_up;
    $fell(srst) |-> ##[1:2] (din_ready && cfg_ready);
  endproperty
  property p_dout_pulse;
    dout_valid |=> !dout_valid [*3];
  endproperty
  property p_latency;
    dout_valid |-> $past(take, 3);
  endproperty
  property p_marker;
    dout_valid |-> first_channel_marker && output_channel_number == '0;
  endproperty
  property p_din_take;
    take |=> din_ready;
  endproperty
  property p_din_wait;
    din_ready && !din_valid |=> din_ready;
  endproperty
  property p_cfg_drop;
    cfg_valid && cfg_ready |=> !cfg_ready;
  endproperty
  property p_cfg_hold;
    (cfg_valid && cfg_ready) ##1 !take |=> !cfg_ready;
  endproperty
  property p_cfg_back;
    !cfg_ready && take |=> cfg_ready;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active right after reset");
  a_rdy_up: assert property (p_rdy_up)
    else $error("ready did not return after reset");
  a_dout_pulse: assert property (p_dout_pulse)
    else $error("outputs closer than the rate");
  a_latency: assert property (p_latency)
    else $error("output not three edges after the frame's last sample");
  a_marker: assert property (p_marker)
    else $error("channel sideband wrong");
  a_din_take: assert property (p_din_take)
    else $error("input ready dropped after a take");
  a_din_wait: assert property (p_din_wait)
    else $error("input ready dropped while waiting");
  a_cfg_drop: assert property (p_cfg_drop)
    else $error("config ready stayed high after a rate");
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config ready rose before the sample");
  a_cfg_back: assert property (p_cfg_back)
    else $error("config ready did not return");
  c_rate: cover property (cfg_valid && cfg_ready);
  c_out: cover property (dout_valid);
  c_rst: cover property ($fell(srst));
endmodule
bind cicms_filter cicms_checker #(.CH_W(CH_W)) u_chk (
  .clk_sys(clk_sys),
  .srst(srst),
  .din_valid(din_valid),
  .din_ready(din_ready),
  .cfg_valid(cfg_valid),
  .cfg_ready(cfg_ready),
  .dout_valid(dout_valid),
  .first_channel_marker(first_channel_marker),
  .output_channel_number(output_channel_number)
);
`default_nettype wire

/* File: cicms_partner.sv */
// Upstream sample master and downstream slave around the filter
`timescale 1ns/100ps
`default_nettype none
module cicms_partner (
  // Clock
  input wire logic clk_sys,
  // Upstream master
  output logic din_valid,
  output logic [15:0] din_data,
  input wire logic din_ready,
  // Downstream slave
  input wire logic dout_valid,
  input wire logic [29:0] dout_data,
  output logic dout_ready
);
  logic [29:0] got_q[$];
  int got_t[$];
  int cyc;
  logic stuck;
  initial begin
    din_valid = 1'b0;
    din_data = 16'h0000;
    dout_ready = 1'b1;
    cyc = 0;
    stuck = 1'b0;
  end
  // No backpressure port, so every valid word is taken
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (dout_valid === 1'b1) begin
      got_q.push_back(dout_data);
      got_t.push_back(cyc);
    end
  end
  task automatic clear;
    got_q.delete();
    got_t.delete();
  endtask
  // Idle data toggles so a stale sample never looks valid
  task automatic send_run(input logic [15:0] base, input int n,
                          input int gap);
    int k;
    int w;
    @(posedge clk_sys);
    for (k = 0; k < n; k++) begin
      repeat (gap) begin
        din_valid <= 1'b0;
        din_data <= ~din_data;
        @(posedge clk_sys);
      end
      din_valid <= 1'b1;
      din_data <= base + k[15:0];
      w = 0;
      do begin
        @(posedge clk_sys);
        w++;
      end while (din_ready !== 1'b1 && w < 64);
      if (w >= 64) begin
        stuck = 1'b1;
      end
    end
    din_valid <= 1'b0;
    din_data <= ~din_data;
  endtask
endmodule
`default_nettype wire

/* File: tb_cic_multirate_stream_filter.sv */
// Testbench for the CIC multirate stream filter as a decimator
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s expected %0h seen %0h", \
  nm, e, g); end end
module tb_cic_multirate_stream_filter;
  logic clk_sys;
  logic srst;
  logic ce;
  logic cfg_valid;
  logic [13:0] cfg_rate;
  logic cfg_ready, din_valid, din_ready, dout_valid, dout_ready, marker;
  logic [15:0] din_data;
  logic [29:0] dout_data;
  logic [0:0] chan;
  int err_count;
  int n_tests;
  int t0;
  cicms_filter uut (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .din_valid(din_valid), .din_data(din_data), .din_ready(din_ready),
    .cfg_valid(cfg_valid), .cfg_rate(cfg_rate), .cfg_ready(cfg_ready),
    .dout_valid(dout_valid), .dout_data(dout_data),
    .first_channel_marker(marker), .output_channel_number(chan),
    .dout_ready(dout_ready));
  cicms_partner p (.clk_sys(clk_sys), .din_valid(din_valid),
    .din_data(din_data), .din_ready(din_ready), .dout_valid(dout_valid),
    .dout_data(dout_data), .dout_ready(dout_ready));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Waits a little past the last output so extras are counted too
  task automatic wait_outs(input int n);
    int w;
    w = 0;
    while (p.got_q.size() < n && w < 100) begin
      @(posedge clk_sys);
      w++;
    end
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK("out_count", n, p.got_q.size())
    if (w >= 100) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic set_rate(input logic [13:0] r);
    int w;
    w = 0;
    @(posedge clk_sys);
    cfg_valid <= 1'b1;
    cfg_rate <= r;
    do begin
      @(posedge clk_sys);
      w++;
    end while (cfg_ready !== 1'b1 && w < 50);
    cfg_valid <= 1'b0;
    cfg_rate <= ~r;
    if (w >= 50) begin
      err_count++;
      tally_and_finish();
    end
    #1;
    `CHK("cfg_ready_drop", 1'b0, cfg_ready)
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    `CHK("dout_valid_rst", 1'b0, dout_valid)
    `CHK("din_ready_rst", 1'b0, din_ready)
    p.clear();
  endtask
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    cfg_valid = 1'b0;
    cfg_rate = 14'h0004;
    err_count = 0;
    n_tests = 0;
    do_reset();
    t0 = p.cyc;
    p.send_run(16'h0001, 12, 0);
    #1;
    `CHK("run_cycles", 13, p.cyc - t0)
    wait_outs(3);
    // First take one edge late, then R samples and two buffer edges
    `CHK("dec4_lat", 7, p.got_t[0] - t0)
    `CHK("dec4_a", 30'h000000A, p.got_q[0])
    `CHK("dec4_b", 30'h000001A, p.got_q[1])
    `CHK("dec4_c", 30'h000002A, p.got_q[2])
    `CHK("dec4_gap", 4, p.got_t[2] - p.got_t[1])
    $display("test initial rate done");
    p.clear();
    set_rate(14'h0007);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("cfg_ready_wait", 1'b0, cfg_ready)
    p.send_run(16'h0001, 14, 0);
    #1;
    `CHK("cfg_ready_back", 1'b1, cfg_ready)
    wait_outs(2);
    `CHK("dec7_a", 30'h000001C, p.got_q[0])
    `CHK("dec7_b", 30'h000004D, p.got_q[1])
    `CHK("dec7_gap", 7, p.got_t[1] - p.got_t[0])
    $display("test rate change done");
    p.clear();
    p.send_run(16'h0003, 7, 2);
    wait_outs(1);
    `CHK("slow_sum", 30'h000002A, p.got_q[0])
    $display("test slow master done");
    p.send_run(16'h0005, 3, 0);
    do_reset();
    p.send_run(16'h0001, 4, 0);
    wait_outs(1);
    `CHK("rst_rate", 30'h000000A, p.got_q[0])
    `CHK("master_stuck", 1'b0, p.stuck)
    $display("test reset mid frame done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
